// ---- hw/srso_defines.vh ----
// Constants for the servo remote status output block
`ifndef SRSO_DEFINES_VH
`define SRSO_DEFINES_VH

// Register byte offsets (Wishbone, one aligned word each)
`define SRSO_ADDR_W          4
`define SRSO_OFS_CTRL        4'h0
`define SRSO_OFS_STATUS      4'h4
`define SRSO_OFS_IRQ_STAT    4'h8
`define SRSO_OFS_IRQ_MASK    4'hc

// Control register fields
`define SRSO_CTRL_TWO_ST     0
`define SRSO_CTRL_RST        1'h0

// Status register fields
`define SRSO_ST_PT_LSB       0
`define SRSO_ST_PT_MSB       7
`define SRSO_ST_TROUBLE      8
`define SRSO_ST_CRD          9
`define SRSO_ST_FRES         10
`define SRSO_ST_MODE         11
`define SRSO_ST_STARTED      12

// Interrupt event bits, same layout in status and mask
`define SRSO_IRQ_W           3
`define SRSO_IRQ_PT_LOAD     0
`define SRSO_IRQ_TROUBLE     1
`define SRSO_IRQ_CRD_LOST    2
`define SRSO_IRQ_RST         3'h0

// Point table code
`define SRSO_PT_W            8
`define SRSO_PT_OFF          8'h00

// Remote output word layout
`define SRSO_WORD_W          16
`define SRSO_WORD_RST        16'h0000
`define SRSO_RX_PT_LSB       2
`define SRSO_RX_PT_MSB       9
`define SRSO_RX_TROUBLE      4'ha
`define SRSO_RX_CRD          4'hb

// Power-up trouble window: 1.5 s at 200 MHz
`define SRSO_STARTUP_MS      1500
`define SRSO_CLK_KHZ         200000
`define SRSO_STARTUP_CNT_W   29

// Pin synchroniser depth
`define SRSO_SYNC_STAGES     3

`endif

// ---- hw/srso_sync.v ----
// Three-stage pin synchroniser with agreement filter
module srso_sync
#(
	parameter W = 2
)
(
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         ce_i,
	input  wire [W-1:0] pin_i,
	output reg  [W-1:0] level_o
);

	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	integer     k;

	// First stage feeds only the second; a bit moves once stages two and three agree
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_q    <= {W{1'b0}};
			s2_q    <= {W{1'b0}};
			s3_q    <= {W{1'b0}};
			level_o <= {W{1'b0}};
		end
		else if (ce_i)
		begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (k = 0; k < W; k = k + 1)
			begin
				if (s2_q[k] == s3_q[k])
					level_o[k] <= s3_q[k];
			end
		end
	end

endmodule

// ---- hw/srso_top.v ----
// Servo remote station status outputs with Wishbone register access
//
// Overview of operation
// - The point table number appears as an unsigned 8-bit code on remote bits 2 to 9, LSB first.
// - All point table bits go OFF at power-on, servo off, during and at the end of homing.
// - A change of the auto/manual selection leaves the point table bits unchanged.
// - The trouble flag rises whenever the protective function shuts off the base drive.
// - With no alarm, the trouble flag falls within 1.5 s of power-up.
// - The trouble flag sits at bit A of word n+1 (n+3 with two stations) and on a pin.
// - The comm-ready flag rises at power-on, falls on an alarm but not in the startup window, at bit B of word n+1 or n+3.
// - The comm-ready flag stays low while the host holds the fault reset input ON.
// - The finished move's point table number loads when the move complete flag turns ON.
//
// Register access over Wishbone and the address map are this design's own decisions.
`include "srso_defines.vh"

module srso_top
#(
	parameter STARTUP_CYC = `SRSO_STARTUP_MS * `SRSO_CLK_KHZ
)
(
	input  wire                     clk_i,
	input  wire                     rst_i,
	input  wire                     ce_i,
	// Wishbone classic slave
	input  wire                     cyc_i,
	input  wire                     stb_i,
	input  wire                     we_i,
	input  wire [`SRSO_ADDR_W-1:0]  adr_i,
	input  wire [3:0]               sel_i,
	input  wire [31:0]              dat_i,
	output reg  [31:0]              dat_o,
	output reg                      ack_o,
	// Drive-side status from the servo core
	input  wire                     servo_on_i,
	input  wire                     home_busy_i,
	input  wire                     home_done_i,
	input  wire                     move_complete_flag_i,
	input  wire [`SRSO_PT_W-1:0]    pt_number_i,
	input  wire                     protect_trip_i,
	// Host remote inputs, asynchronous
	input  wire                     fault_reset_input_i,
	input  wire                     auto_manual_select_i,
	// Remote output words and external pin
	output reg  [`SRSO_WORD_W-1:0]  rx_word1_o,
	output reg  [`SRSO_WORD_W-1:0]  rx_word2_o,
	output reg  [`SRSO_WORD_W-1:0]  rx_word3_o,
	output reg                      trouble_pin_o,
	output reg                      irq_o
);

	// Derived startup count, exact since 1.5 s is a whole number of cycles
	localparam integer                   STARTUP_LAST_I = STARTUP_CYC - 1;
	localparam [`SRSO_STARTUP_CNT_W-1:0] STARTUP_LAST   = STARTUP_LAST_I[`SRSO_STARTUP_CNT_W-1:0];

	// Synchronised host inputs
	wire                            fres_s;
	wire                            mode_s;

	// Control and state
	reg                             two_st_q;
	reg  [`SRSO_PT_W-1:0]           pt_q;
	reg  [`SRSO_PT_W-1:0]           pt_d;
	reg                             move_complete_flag_prev_q;
	reg                             alarm_q;
	reg                             started_q;
	reg  [`SRSO_STARTUP_CNT_W-1:0]  start_cnt_q;
	reg                             trouble_q;
	reg                             crd_q;
	reg                             crd_d;
	reg  [`SRSO_IRQ_W-1:0]          irq_stat_q;
	reg  [`SRSO_IRQ_W-1:0]          irq_mask_q;
	reg  [`SRSO_IRQ_W-1:0]          irq_evt;
	reg                             pt_load;

	// Bus decode
	wire                            bus_req;
	wire                            bus_wr;
	wire                            trouble_d;

	// Place a status flag into a remote word at the given bit
	function [`SRSO_WORD_W-1:0] put_bit;
		input [3:0] pos;
		input       val;
		begin
			put_bit      = `SRSO_WORD_RST;
			put_bit[pos] = val;
		end
	endfunction

	// Reset input and mode select come off the link, so three flops each
	srso_sync
	#(
		.W (2)
	)
	u_sync
	(
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.pin_i   ({auto_manual_select_i, fault_reset_input_i}),
		.level_o ({mode_s, fres_s})
	);

	// Request taken on the first cycle, ack pulses once
	assign bus_req = cyc_i & stb_i & ~ack_o;
	assign bus_wr  = bus_req & we_i;

	// Point table code next value; clearing conditions outrank a load
	always @*
	begin
		pt_d    = pt_q;
		pt_load = 1'b0;
		if (!servo_on_i || home_busy_i || home_done_i)
			pt_d = `SRSO_PT_OFF;
		else if (move_complete_flag_i && !move_complete_flag_prev_q)
		begin
			pt_d    = pt_number_i;
			pt_load = 1'b1;
		end
		// mode change holds code
		// A toggle of mode_s takes no branch here, so the code simply stays.
	end

	// Power-up window: trouble shows until the count runs out
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			start_cnt_q <= {`SRSO_STARTUP_CNT_W{1'b0}};
			started_q   <= 1'b0;
		end
		else if (ce_i && !started_q)
		begin
			if (start_cnt_q == STARTUP_LAST)
				started_q <= 1'b1;
			else
				start_cnt_q <= start_cnt_q + 1'b1;
		end
	end

	// Alarm latch: a trip stays until the host pulses reset with the cause gone
	always @(posedge clk_i)
	begin
		if (rst_i)
			alarm_q <= 1'b0;
		else if (ce_i)
		begin
			if (protect_trip_i)
				alarm_q <= 1'b1;
			else if (fres_s)
				alarm_q <= 1'b0;
		end
	end

	// Trouble covers the startup window as well as a real alarm
	assign trouble_d = alarm_q | protect_trip_i | ~started_q;

	// Comm ready falls on an alarm or while reset is held, not in startup
	always @*
	begin
		crd_d = ~(alarm_q | protect_trip_i);
		if (fres_s)
			crd_d = 1'b0;
	end

	// Event sources for the interrupt status
	always @*
	begin
		irq_evt                    = `SRSO_IRQ_RST;
		irq_evt[`SRSO_IRQ_PT_LOAD] = pt_load;
		irq_evt[`SRSO_IRQ_TROUBLE] = alarm_q == 1'b0 && protect_trip_i;
		irq_evt[`SRSO_IRQ_CRD_LOST] = crd_q & ~crd_d;
	end

	// Core status state
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pt_q        <= `SRSO_PT_OFF;
			move_complete_flag_prev_q <= 1'b0;
			trouble_q   <= 1'b1;
			crd_q       <= 1'b1;
		end
		else if (ce_i)
		begin
			pt_q        <= pt_d;
			move_complete_flag_prev_q <= move_complete_flag_i;
			trouble_q   <= trouble_d;
			crd_q       <= crd_d;
		end
	end

	// Remote output words; positions unused in a configuration read as OFF
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_word1_o    <= put_bit(`SRSO_RX_CRD, 1'b1) | put_bit(`SRSO_RX_TROUBLE, 1'b1);
			rx_word2_o    <= `SRSO_WORD_RST;
			rx_word3_o    <= `SRSO_WORD_RST;
			trouble_pin_o <= 1'b1;
		end
		else if (ce_i)
		begin
			// code on bits 2 to 9
			rx_word2_o <= {{(`SRSO_WORD_W - `SRSO_RX_PT_MSB - 1){1'b0}}, pt_d,
				{`SRSO_RX_PT_LSB{1'b0}}};
			if (two_st_q)
			begin
				rx_word1_o <= `SRSO_WORD_RST;
				rx_word3_o <= put_bit(`SRSO_RX_TROUBLE, trouble_d)
					| put_bit(`SRSO_RX_CRD, crd_d);
			end
			else
			begin
				rx_word1_o <= put_bit(`SRSO_RX_TROUBLE, trouble_d)
					| put_bit(`SRSO_RX_CRD, crd_d);
				rx_word3_o <= `SRSO_WORD_RST;
			end
			trouble_pin_o <= trouble_d;
		end
	end

	// Control, mask and sticky status; a new event beats a same-cycle clear
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			two_st_q   <= `SRSO_CTRL_RST;
			irq_mask_q <= `SRSO_IRQ_RST;
			irq_stat_q <= `SRSO_IRQ_RST;
		end
		else if (ce_i)
		begin
			if (bus_wr && sel_i[0] && adr_i == `SRSO_OFS_CTRL)
				two_st_q <= dat_i[`SRSO_CTRL_TWO_ST];
			if (bus_wr && sel_i[0] && adr_i == `SRSO_OFS_IRQ_MASK)
				irq_mask_q <= dat_i[`SRSO_IRQ_W-1:0];
			if (bus_wr && sel_i[0] && adr_i == `SRSO_OFS_IRQ_STAT)
				irq_stat_q <= (irq_stat_q & ~dat_i[`SRSO_IRQ_W-1:0]) | irq_evt;
			else
				irq_stat_q <= irq_stat_q | irq_evt;
		end
	end

	// Level interrupt from any unmasked pending event
	always @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else if (ce_i)
			irq_o <= |(irq_stat_q & irq_mask_q);
	end

	// Bus answer: one cycle after the request, unmapped reads give zero
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			ack_o <= bus_req;
			dat_o <= 32'h0000_0000;
			if (bus_req && !we_i)
			begin
				case (adr_i)
				`SRSO_OFS_CTRL:
				begin
					dat_o[`SRSO_CTRL_TWO_ST] <= two_st_q;
				end
				`SRSO_OFS_STATUS:
				begin
					dat_o[`SRSO_ST_PT_MSB:`SRSO_ST_PT_LSB] <= pt_q;
					dat_o[`SRSO_ST_TROUBLE]               <= trouble_q;
					dat_o[`SRSO_ST_CRD]                   <= crd_q;
					dat_o[`SRSO_ST_FRES]                  <= fres_s;
					dat_o[`SRSO_ST_MODE]                  <= mode_s;
					dat_o[`SRSO_ST_STARTED]               <= started_q;
				end
				`SRSO_OFS_IRQ_STAT:
				begin
					dat_o[`SRSO_IRQ_W-1:0] <= irq_stat_q;
				end
				`SRSO_OFS_IRQ_MASK:
				begin
					dat_o[`SRSO_IRQ_W-1:0] <= irq_mask_q;
				end
				default:
				begin
					dat_o <= 32'h0000_0000;
				end
				endcase
			end
		end
	end

endmodule

// ---- tb/srso_chk_sva.sv ----
// Checker for the servo remote status outputs
module srso_chk
#(
	parameter STARTUP_CYC = 20
)
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic        servo_on_i,
	input wire logic        home_busy_i,
	input wire logic        home_done_i,
	input wire logic        move_complete_flag_i,
	input wire logic [7:0]  pt_number_i,
	input wire logic        protect_trip_i,
	input wire logic        fault_reset_input_i,
	input wire logic [15:0] rx_word1_o,
	input wire logic [15:0] rx_word2_o,
	input wire logic [15:0] rx_word3_o,
	input wire logic        trouble_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] up_q;
	logic        trip_q;
	logic        act;

	// Cycles since reset; a trip voids the end-of-startup check
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			up_q   <= 32'h0;
			trip_q <= 1'b0;
		end
		else if (ce_i)
		begin
			up_q   <= up_q + 32'h1;
			trip_q <= trip_q | protect_trip_i;
		end
	end

	// Loads allowed only when not forced off
	assign act = servo_on_i & ~home_busy_i & ~home_done_i & ce_i;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Steps of a bus answer and of a code load
	sequence s_ack; ack_o ##1 !ack_o; endsequence
	sequence s_load; $rose(move_complete_flag_i) && act; endsequence

	property p_load; s_load |=> rx_word2_o == {6'h00, $past(pt_number_i), 2'h0}; endproperty
	property p_clear; !act && ce_i |=> rx_word2_o == 16'h0000; endproperty
	property p_hold; act && !$rose(move_complete_flag_i) |=> $stable(rx_word2_o); endproperty
	property p_trip; protect_trip_i && ce_i |=> trouble_pin_o && (rx_word1_o[10] || rx_word3_o[10]);
	endproperty
	property p_drop; protect_trip_i && ce_i |=> !rx_word1_o[11] && !rx_word3_o[11]; endproperty
	property p_fres; fault_reset_input_i [*5] |=> !rx_word1_o[11] && !rx_word3_o[11]; endproperty
	property p_start; up_q > 0 && up_q < STARTUP_CYC |-> trouble_pin_o; endproperty
	property p_end; !trip_q && up_q >= STARTUP_CYC + 2 |-> !trouble_pin_o; endproperty
	property p_one; !((|rx_word1_o) && (|rx_word3_o)); endproperty
	property p_ack; cyc_i && stb_i && !ack_o && ce_i |=> s_ack; endproperty

	a_load: assert property (p_load)
		else $error("code not loaded");
	a_clear: assert property (p_clear)
		else $error("code not cleared");
	a_hold: assert property (p_hold)
		else $error("code changed");
	a_trip: assert property (p_trip)
		else $error("trouble missing");
	a_drop: assert property (p_drop)
		else $error("ready kept on trip");
	a_fres: assert property (p_fres)
		else $error("ready during reset input");
	a_start: assert property (p_start)
		else $error("trouble left early");
	a_end: assert property (p_end)
		else $error("trouble stuck");
	a_one: assert property (p_one)
		else $error("both station words used");
	a_ack: assert property (p_ack)
		else $error("bad ack");
endmodule

bind srso_top srso_chk #(.STARTUP_CYC(STARTUP_CYC)) i_srso_chk (.clk_i, .rst_i, .ce_i,
	.cyc_i, .stb_i, .ack_o, .servo_on_i, .home_busy_i, .home_done_i, .move_complete_flag_i,
	.pt_number_i, .protect_trip_i, .fault_reset_input_i, .rx_word1_o, .rx_word2_o,
	.rx_word3_o, .trouble_pin_o);

// ---- tb/srso_host.sv ----
// Host master model: drives remote inputs, reads station words
module srso_host
(
	input  wire logic        clk_i,
	input  wire logic        two_st_i,
	input  wire logic        fres_req_i,
	input  wire logic        mode_req_i,
	input  wire logic [15:0] w1_i,
	input  wire logic [15:0] w3_i,
	output logic             fres_o,
	output logic             mode_o,
	output logic             trbl_o,
	output logic             rdy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	assign trbl_o = two_st_i ? w3_i[10] : w1_i[10];
	assign rdy_o  = two_st_i ? w3_i[11] : w1_i[11];

	// Remote inputs launched after each edge
	always @(posedge clk_i)
	begin
		fres_o <= fres_req_i;
		mode_o <= mode_req_i;
	end
endmodule

// ---- tb/srso_top_tb.sv ----
// Testbench for the servo remote status outputs
module srso_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [3:0]  adr_i = 4'h0, sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0, rd;
	logic        servo_on_i = 1, home_busy_i = 0, home_done_i = 0, protect_trip_i = 0;
	logic        move_complete_flag_i = 0, fres_req = 0, mode_req = 0, two_st = 0;
	logic [7:0]  pt_number_i = 8'h00;
	logic        fault_reset_input_i, auto_manual_select_i, trbl, rdy;
	logic [7:0]  codes [5] = '{8'h01, 8'h03, 8'h04, 8'hfe, 8'hff};
	wire  [31:0] dat_o;
	wire         ack_o, trouble_pin_o, irq_o;
	wire  [15:0] rx_word1_o, rx_word2_o, rx_word3_o;
	int          n_mismatch = 0, n_tests = 0, n_cyc = 0;

	srso_top #(.STARTUP_CYC(20)) i_srso_top (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i,
		.adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .servo_on_i, .home_busy_i, .home_done_i,
		.move_complete_flag_i, .pt_number_i, .protect_trip_i, .fault_reset_input_i,
		.auto_manual_select_i, .rx_word1_o, .rx_word2_o, .rx_word3_o, .trouble_pin_o, .irq_o);
	srso_host i_srso_host (.clk_i, .two_st_i(two_st), .fres_req_i(fres_req),
		.mode_req_i(mode_req), .w1_i(rx_word1_o), .w3_i(rx_word3_o),
		.fres_o(fault_reset_input_i), .mode_o(auto_manual_select_i), .trbl_o(trbl), .rdy_o(rdy));

	always #2.5 clk_i = ~clk_i;

	task report_and_stop;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard, well above the run length
	always @(posedge clk_i)
	begin
		n_cyc++;
		if (n_cyc == 4000)
		begin
			n_mismatch++;
			report_and_stop;
		end
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask

	task wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Classic single cycle; waits for ack under a bound
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			t++;
		end
		while (ack_o !== 1'b1 && t < 50);
		chk(ack_o, 1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task load(input logic [7:0] c);
		@(posedge clk_i);
		pt_number_i <= c;
		move_complete_flag_i <= 1'b1;
		@(posedge clk_i);
		move_complete_flag_i <= 1'b0;
		wt(2);
	endtask

	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wt(1);
		chk(rx_word2_o, 0);
		chk(rdy, 1);
		chk(trouble_pin_o, 1);
		wb(0, 4'h0, 0);
		chk(rd, 0);
		wt(25);
		chk(trbl, 0);
		foreach (codes[i])
		begin
			load(codes[i]);
			chk(rx_word2_o, {6'h00, codes[i], 2'h0});
			wb(0, 4'h4, 0);
			chk(rd[7:0], codes[i]);
		end
		wb(1, 4'hc, 1);
		wb(1, 4'h8, 7);
		load(8'h11);
		chk(irq_o, 1);
		wb(1, 4'h8, 1);
		wt(2);
		chk(irq_o, 0);
		wb(1, 4'hc, 0);
		load(8'h22);
		chk(irq_o, 0);
		wb(0, 4'h8, 0);
		chk(rd[0], 1);
		repeat (2)
		begin
			@(posedge clk_i) mode_req <= ~mode_req;
			wt(8);
			chk(rx_word2_o, 16'h0088);
			wb(0, 4'h4, 0);
			chk(rd[11], mode_req);
		end
		for (int i = 0; i < 3; i++)
		begin
			load(8'h33);
			@(posedge clk_i);
			servo_on_i <= i != 0;
			home_busy_i <= i == 1;
			home_done_i <= i == 2;
			wt(2);
			chk(rx_word2_o, 0);
			@(posedge clk_i);
			{servo_on_i, home_busy_i, home_done_i} <= 3'b100;
		end
		for (int s = 0; s < 2; s++)
		begin
			@(posedge clk_i) protect_trip_i <= 1'b1;
			wt(2);
			chk(trouble_pin_o, 1);
			chk(trbl, 1);
			chk(rdy, 0);
			chk(rx_word1_o[11:10], s ? 2'b00 : 2'b01);
			chk(rx_word3_o[11:10], s ? 2'b01 : 2'b00);
			wb(0, 4'h8, 0);
			chk(rd[2:1], 2'b11);
			wb(1, 4'h8, 6);
			@(posedge clk_i);
			protect_trip_i <= 1'b0;
			fres_req <= 1'b1;
			wt(8);
			chk(rdy, 0);
			@(posedge clk_i) fres_req <= 1'b0;
			wt(8);
			chk(rdy, 1);
			two_st <= 1'b1;
			wb(1, 4'h0, 1);
			wt(2);
		end
		wb(0, 4'h2, 0);
		chk(rd, 0);
		report_and_stop;
	end
endmodule
